// ### hw/gsir_regs.svh
// Register indices, bit positions and reset values of the status/interrupt bank.
// Assumes APB byte addresses equal four times the register index.
`ifndef GSIR_REGS_SVH
`define GSIR_REGS_SVH

`define GSIR_ADDR_W        7
`define GSIR_IDX_W         5

// Register indices; byte address is index times four
`define GSIR_IDX_ENABLE    5'h03
`define GSIR_IDX_HIGH      5'h11
`define GSIR_IDX_LOW       5'h13
`define GSIR_IDX_PROTO     5'h15
`define GSIR_IDX_LINES     5'h17
`define GSIR_IDX_SECCMD    5'h1D
`define GSIR_IDX_DATA      5'h1F

// First cause register
`define GSIR_HI_ANY_HIGH   7
`define GSIR_HI_ANY_LOW    6
`define GSIR_HI_BYTE_RX    5
`define GSIR_HI_READY      4
`define GSIR_HI_END        3
`define GSIR_HI_SERIAL_POLL_ACTIVE       2
`define GSIR_HI_REMLOC     1
`define GSIR_HI_ADDRCHG    0

// Second cause register
`define GSIR_LO_TRIGGER    7
`define GSIR_LO_HS_ERROR   6
`define GSIR_LO_UNKNOWN    5
`define GSIR_LO_SECADDR    4
`define GSIR_LO_DCAS       3
`define GSIR_LO_MYADDR     2
`define GSIR_LO_SRQ        1
`define GSIR_LO_IFC        0

// Interrupt/DMA enable register and its read-back view
`define GSIR_EN_IRQ        7
`define GSIR_EN_REQUEST    6
`define GSIR_EN_DMA1       1
`define GSIR_EN_DMA0       0

// Edge detector lanes
`define GSIR_EDGE_SERIAL_POLL_ACTIVE     3
`define GSIR_EDGE_DCAS     2
`define GSIR_EDGE_REM      1
`define GSIR_EDGE_ADDR     0
`define GSIR_EDGE_ANY_MASK 4'h3

`define GSIR_RST_BYTE      8'h00
`define GSIR_RST_WORD      32'h0000_0000

`endif

// ### hw/gsir_pkg.sv
// Types shared by the status/interrupt bank, its bus model and its bench.
// Assumes all inputs are synchronous to pclk.
package gsir_pkg;

	typedef struct packed {
		logic       psel;
		logic       penable;
		logic       pwrite;
		logic [6:0] paddr;
		logic [31:0] pwdata;
	} gsir_apb_req_t;

	// Field order matches the line status register, bit 7 first
	typedef struct packed {
		logic atn;
		logic dav;
		logic ndac;
		logic nrfd;
		logic eoi;
		logic srq;
		logic ifc;
		logic ren;
	} gsir_lines_t;

	// Field order matches the protocol state register, bit 7 first
	typedef struct packed {
		logic remote_state;
		logic local_lockout_state;
		logic atn_true;
		logic listener_primary_addressed;
		logic talker_primary_addressed;
		logic listener_addressed;
		logic talker_addressed;
		logic last_address_lsb;
	} gsir_proto_t;

	typedef struct packed {
		logic serial_poll_active;
		logic device_clear_active;
		logic active_controller;
		logic extended_addressing;
	} gsir_mode_t;

	typedef struct packed {
		logic byte_received;
		logic ready_for_byte;
		logic end_seen;
		logic trigger_received;
		logic handshake_error;
		logic unknown_command;
		logic secondary_address;
		logic own_address_received;
		logic service_request_seen;
		logic interface_clear_seen;
		logic secondary_command_seen;
	} gsir_evt_t;

endpackage

// ### hw/gsir_edge.sv
// Edge detector for interface state levels, one lane per level.
// Assumes levels are synchronous to pclk; first cycle after reset only arms.
`timescale 1ns/1ps

module gsir_edge
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [3:0] level,
	input  wire logic [3:0] any_change,
	output logic      [3:0] pulse
);

	typedef struct packed {
		logic       armed;
		logic [3:0] prev;
	} gsir_edge_state_t;

	gsir_edge_state_t s;
	gsir_edge_state_t next_s;

	always_comb
	begin
		next_s       = s;
		next_s.armed = 1'b1;
		next_s.prev  = level;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s <= '0;
		else
			s <= next_s;
	end

	// Unarmed first cycle avoids false events from levels high at reset
	for (genvar i = 0; i < 4; i++)
	begin : g_lane
		assign pulse[i] = s.armed & (any_change[i] ? (level[i] ^ s.prev[i])
		                                            : (level[i] & ~s.prev[i]));
	end

endmodule

// ### hw/gsir_top.sv
// Status and interrupt register bank of an instrument-bus interface, APB slave.
// Assumes the protocol engine supplies one-cycle event pulses and live levels.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "gsir_regs.svh"

// Overview of operation
// - First cause bit 7 shows a pending enabled cause in bits 5 to 0.
// - First cause bit 6 shows a pending enabled cause in the second register.
// - First cause bit 5 sets when a data byte is accepted.
// - First cause bit 4 sets when the next outgoing byte can be taken.
// - First cause bit 3 sets on EOI while ATN is false.
// - First cause bit 2 sets on entry to serial poll active.
// - Bit 1 sets on remote/local change, bit 0 on addressed change.
// - Second cause bit 7 sets on group execute trigger.
// - Second cause bit 6 sets on incomplete source handshake.
// - Second cause bit 5 sets on an unrecognised command.
// - Second cause bit 4 sets on secondary address in extended mode.
// - Second cause bit 3 sets on entry to device clear active.
// - Bit 2 own address, bit 1 service request, bit 0 interface clear.
// - Protocol state register shows the addressing states and last address bit.
// - Line status register shows eight control line levels, one means true.
// - NDAC/NRFD valid only as talker, SRQ only as active controller.
// - Pass-through register holds data lines of detected secondary command.
// - Data-line register shows the live eight data lines.
// - Enable bit 7 allows host interrupts; bits 6 to 2 ignored.
// - Enable bits 1 and 0 enable DMA channels 1 and 0.
// - First mask bits 5 to 0 enable matching causes; 7 and 6 unused.
// - Second mask bits enable matching second-register causes.
// - Reading either cause register or data lines has a side effect.
module gsir_top
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire gsir_pkg::gsir_apb_req_t apb_req,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire gsir_pkg::gsir_lines_t lines,
	input  wire logic [7:0]            dio,
	input  wire gsir_pkg::gsir_proto_t proto,
	input  wire gsir_pkg::gsir_mode_t  mode,
	input  wire gsir_pkg::gsir_evt_t   evt,
	output logic                       irq,
	output logic      [1:0]            dma_enable,
	output logic                       data_lines_read
);

	typedef struct packed {
		logic        irq_en;
		logic [1:0]  dma;
		logic [5:0]  mask_high;
		logic [7:0]  mask_low;
		logic [5:0]  cause_high;
		logic [7:0]  cause_low;
		logic [5:0]  clr_high;
		logic [7:0]  clr_low;
		logic [7:0]  sec_cmd;
		logic [31:0] rdata;
		logic        irq;
	} gsir_state_t;

	gsir_state_t s;
	gsir_state_t next_s;

	logic [`GSIR_IDX_W-1:0] idx;
	logic                   aligned;
	logic                   setup;
	logic                   access;
	logic                   rd_ok;
	logic                   wr_ok;
	logic                   any_high;
	logic                   any_low;
	logic [5:0]             set_high;
	logic [7:0]             set_low;
	logic [3:0]             edge_level;
	logic [3:0]             edge_pulse;
	gsir_pkg::gsir_lines_t  lines_view;
	logic [7:0]             view;

	assign idx     = apb_req.paddr[`GSIR_ADDR_W-1:2];
	assign aligned = (apb_req.paddr[1:0] == 2'h0);
	assign setup   = apb_req.psel & ~apb_req.penable;
	assign access  = apb_req.psel & apb_req.penable;

	always_comb
	begin
		rd_ok = 1'b0;
		wr_ok = 1'b0;
		case (idx)
			`GSIR_IDX_ENABLE, `GSIR_IDX_HIGH, `GSIR_IDX_LOW:
			begin
				rd_ok = aligned;
				wr_ok = aligned;
			end
			`GSIR_IDX_PROTO, `GSIR_IDX_LINES, `GSIR_IDX_SECCMD, `GSIR_IDX_DATA:
				rd_ok = aligned;
			default:
			begin
				rd_ok = 1'b0;
				wr_ok = 1'b0;
			end
		endcase
	end

	// Unused mask bits 7 and 6 are not stored
	assign any_high = |(s.cause_high & s.mask_high);
	assign any_low  = |(s.cause_low & s.mask_low);

	gsir_edge u_edge
	(
		.pclk       (pclk),
		.presetn    (presetn),
		.level      (edge_level),
		.any_change (`GSIR_EDGE_ANY_MASK),
		.pulse      (edge_pulse)
	);

	assign edge_level[`GSIR_EDGE_SERIAL_POLL_ACTIVE] = mode.serial_poll_active;
	assign edge_level[`GSIR_EDGE_DCAS] = mode.device_clear_active;
	assign edge_level[`GSIR_EDGE_REM]  = proto.remote_state;
	assign edge_level[`GSIR_EDGE_ADDR] = proto.listener_addressed | proto.talker_addressed;

	always_comb
	begin
		set_high                    = '0;
		set_high[`GSIR_HI_BYTE_RX]  = evt.byte_received;
		set_high[`GSIR_HI_READY]    = evt.ready_for_byte;
		set_high[`GSIR_HI_END]      = evt.end_seen & ~lines.atn;
		set_high[`GSIR_HI_SERIAL_POLL_ACTIVE]     = edge_pulse[`GSIR_EDGE_SERIAL_POLL_ACTIVE];
		set_high[`GSIR_HI_REMLOC]   = edge_pulse[`GSIR_EDGE_REM];
		set_high[`GSIR_HI_ADDRCHG]  = edge_pulse[`GSIR_EDGE_ADDR];
		set_low                     = '0;
		set_low[`GSIR_LO_TRIGGER]   = evt.trigger_received;
		set_low[`GSIR_LO_HS_ERROR]  = evt.handshake_error;
		set_low[`GSIR_LO_UNKNOWN]   = evt.unknown_command;
		set_low[`GSIR_LO_SECADDR]   = evt.secondary_address & mode.extended_addressing;
		set_low[`GSIR_LO_DCAS]      = edge_pulse[`GSIR_EDGE_DCAS];
		set_low[`GSIR_LO_MYADDR]    = evt.own_address_received;
		set_low[`GSIR_LO_SRQ]       = evt.service_request_seen;
		set_low[`GSIR_LO_IFC]       = evt.interface_clear_seen;
	end

	always_comb
	begin
		lines_view      = lines;
		lines_view.ndac = lines.ndac & proto.talker_addressed;
		lines_view.nrfd = lines.nrfd & proto.talker_addressed;
		lines_view.srq  = lines.srq & mode.active_controller;
	end

	// Read view of the addressed register, sampled in the setup cycle
	always_comb
	begin
		view = `GSIR_RST_BYTE;
		case (idx)
			`GSIR_IDX_ENABLE:
			begin
				view[`GSIR_EN_IRQ]     = s.irq_en;
				view[`GSIR_EN_REQUEST] = s.irq;
				view[`GSIR_EN_DMA1]    = s.dma[1];
				view[`GSIR_EN_DMA0]    = s.dma[0];
			end
			`GSIR_IDX_HIGH:
				view = {any_high, any_low, s.cause_high};
			`GSIR_IDX_LOW:
				view = s.cause_low;
			`GSIR_IDX_PROTO:
				view = proto;
			`GSIR_IDX_LINES:
				view = lines_view;
			`GSIR_IDX_SECCMD:
				view = s.sec_cmd;
			`GSIR_IDX_DATA:
				view = dio;
			default:
				view = `GSIR_RST_BYTE;
		endcase
		if (!aligned)
			view = `GSIR_RST_BYTE;
	end

	always_comb
	begin
		next_s = s;

		// Only bits shown to software are cleared, so events between setup
		// and access survive; a set in the clearing cycle wins
		if (setup && !apb_req.pwrite)
		begin
			next_s.rdata    = {24'h00_0000, view};
			next_s.clr_high = (idx == `GSIR_IDX_HIGH && aligned) ? s.cause_high : 6'h00;
			next_s.clr_low  = (idx == `GSIR_IDX_LOW && aligned) ? s.cause_low : 8'h00;
		end
		else if (access)
		begin
			next_s.clr_high = 6'h00;
			next_s.clr_low  = 8'h00;
		end

		next_s.cause_high = s.cause_high | set_high;
		next_s.cause_low  = s.cause_low | set_low;
		if (access && !apb_req.pwrite)
		begin
			next_s.cause_high = (s.cause_high & ~s.clr_high) | set_high;
			next_s.cause_low  = (s.cause_low & ~s.clr_low) | set_low;
		end

		if (evt.secondary_command_seen)
			next_s.sec_cmd = dio;

		if (access && apb_req.pwrite && wr_ok)
		begin
			case (idx)
				`GSIR_IDX_ENABLE:
				begin
					next_s.irq_en = apb_req.pwdata[`GSIR_EN_IRQ];
					next_s.dma    = apb_req.pwdata[`GSIR_EN_DMA1:`GSIR_EN_DMA0];
				end
				`GSIR_IDX_HIGH:
					next_s.mask_high = apb_req.pwdata[`GSIR_HI_BYTE_RX:`GSIR_HI_ADDRCHG];
				`GSIR_IDX_LOW:
					next_s.mask_low = apb_req.pwdata[7:0];
				default:
					next_s.mask_low = s.mask_low;
			endcase
		end

		next_s.irq = s.irq_en & (any_high | any_low);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s <= '0;
		else
			s <= next_s;
	end

	// Zero wait states: read data was captured in the setup cycle
	assign pready          = 1'b1;
	assign pslverr         = access & (apb_req.pwrite ? ~wr_ok : ~rd_ok);
	assign prdata          = s.rdata;
	assign irq             = s.irq;
	assign dma_enable      = s.dma;
	// Lets the bus engine release a data-line holdoff
	assign data_lines_read = access & ~apb_req.pwrite & aligned
	                         & (idx == `GSIR_IDX_DATA);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence rd_high_seq;
		setup && !apb_req.pwrite && aligned && idx == `GSIR_IDX_HIGH ##1 access;
	endsequence

	sequence rd_lines_seq;
		setup && !apb_req.pwrite && aligned && idx == `GSIR_IDX_LINES ##1 access;
	endsequence

	sequence wr_enable_seq;
		access && apb_req.pwrite && aligned && idx == `GSIR_IDX_ENABLE;
	endsequence

	sequence rd_proto_seq;
		setup && !apb_req.pwrite && aligned && idx == `GSIR_IDX_PROTO ##1 access;
	endsequence

	sequence rd_data_seq;
		setup && !apb_req.pwrite && aligned && idx == `GSIR_IDX_DATA ##1 access;
	endsequence

	sequence wr_high_seq;
		access && apb_req.pwrite && aligned && idx == `GSIR_IDX_HIGH;
	endsequence

	sequence wr_low_seq;
		access && apb_req.pwrite && aligned && idx == `GSIR_IDX_LOW;
	endsequence

	AST_HIGH_ANY: assert property (rd_high_seq |-> prdata[7] == $past(any_high))
		else $error("first cause bit 7 does not reflect masked causes");
	AST_LOW_ANY: assert property (rd_high_seq |-> prdata[6] == $past(any_low))
		else $error("first cause bit 6 does not reflect second register");
	AST_BYTE_RX: assert property (evt.byte_received |=> s.cause_high[`GSIR_HI_BYTE_RX])
		else $error("byte received cause not set");
	AST_READY: assert property (evt.ready_for_byte |=> s.cause_high[`GSIR_HI_READY])
		else $error("ready for byte cause not set");
	AST_END_SET: assert property (evt.end_seen && !lines.atn |=> s.cause_high[`GSIR_HI_END])
		else $error("end cause not set with ATN false");
	AST_END_ATN: assert property (!s.cause_high[`GSIR_HI_END] && (!evt.end_seen || lines.atn)
		|=> !s.cause_high[`GSIR_HI_END])
		else $error("end cause set while ATN true");
	AST_GET: assert property (evt.trigger_received |=> s.cause_low[`GSIR_LO_TRIGGER])
		else $error("trigger cause not set");
	AST_SECADDR: assert property (evt.secondary_address && mode.extended_addressing
		|=> s.cause_low[`GSIR_LO_SECADDR])
		else $error("secondary address cause not set");
	AST_LINES_NDAC: assert property (rd_lines_seq |-> prdata[5] ==
		($past(lines.ndac) & $past(proto.talker_addressed)))
		else $error("NDAC view not gated by talker state");
	AST_SECCMD: assert property (evt.secondary_command_seen |=> s.sec_cmd == $past(dio))
		else $error("pass-through byte not captured");
	AST_DMA: assert property (wr_enable_seq |=> dma_enable == $past(apb_req.pwdata[1:0]))
		else $error("DMA enables not written");
	AST_RD_CLEAR: assert property (rd_high_seq ##0 set_high == 6'h00
		|=> (s.cause_high & $past(s.clr_high)) == 6'h00)
		else $error("read did not clear shown causes");
	AST_IRQ_ON: assert property (s.irq_en && (any_high || any_low) |=> irq)
		else $error("interrupt not raised");
	AST_IRQ_OFF: assert property (!s.irq_en |=> !irq)
		else $error("interrupt raised while disabled");
	// Level edges in the cycle that follows reset release are not reported
	AST_SERIAL_POLL_ACTIVE: assert property ($rose(mode.serial_poll_active) && $past(presetn)
		|=> s.cause_high[`GSIR_HI_SERIAL_POLL_ACTIVE])
		else $error("serial poll entry cause not set");
	AST_REMLOC: assert property ($changed(proto.remote_state) && $past(presetn)
		|=> s.cause_high[`GSIR_HI_REMLOC])
		else $error("remote/local change cause not set");
	AST_ADDRCHG: assert property ($changed(edge_level[`GSIR_EDGE_ADDR]) && $past(presetn)
		|=> s.cause_high[`GSIR_HI_ADDRCHG])
		else $error("addressed change cause not set");
	AST_DCAS: assert property ($rose(mode.device_clear_active) && $past(presetn)
		|=> s.cause_low[`GSIR_LO_DCAS])
		else $error("device clear entry cause not set");
	AST_HS_ERR: assert property (evt.handshake_error |=> s.cause_low[`GSIR_LO_HS_ERROR])
		else $error("handshake error cause not set");
	AST_UNKNOWN: assert property (evt.unknown_command |=> s.cause_low[`GSIR_LO_UNKNOWN])
		else $error("unknown command cause not set");
	AST_OWN_ADDR: assert property (evt.own_address_received |=> s.cause_low[`GSIR_LO_MYADDR])
		else $error("own address cause not set");
	AST_SRQ: assert property (evt.service_request_seen |=> s.cause_low[`GSIR_LO_SRQ])
		else $error("service request cause not set");
	AST_IFC: assert property (evt.interface_clear_seen |=> s.cause_low[`GSIR_LO_IFC])
		else $error("interface clear cause not set");
	AST_PROTO: assert property (rd_proto_seq |-> prdata[7:0] == $past(proto))
		else $error("protocol state view wrong");
	AST_LINES_ATN: assert property (rd_lines_seq |-> prdata[7] == $past(lines.atn))
		else $error("ATN level view wrong");
	AST_LINES_SRQ: assert property (rd_lines_seq |-> prdata[2] ==
		($past(lines.srq) & $past(mode.active_controller)))
		else $error("SRQ view not gated by controller state");
	AST_DATA: assert property (rd_data_seq |-> prdata[7:0] == $past(dio))
		else $error("data line view wrong");
	AST_DLR: assert property (rd_data_seq |-> data_lines_read)
		else $error("data line read not signalled");
	AST_MASK_HIGH: assert property (wr_high_seq
		|=> s.mask_high == $past(apb_req.pwdata[`GSIR_HI_BYTE_RX:`GSIR_HI_ADDRCHG]))
		else $error("first mask not written");
	AST_MASK_LOW: assert property (wr_low_seq |=> s.mask_low == $past(apb_req.pwdata[7:0]))
		else $error("second mask not written");
	AST_IRQ_EN: assert property (wr_enable_seq |=> s.irq_en == $past(apb_req.pwdata[7]))
		else $error("interrupt enable not written");
	AST_IRQ_IDLE: assert property (!(any_high || any_low) |=> !irq)
		else $error("interrupt raised with no masked cause");

endmodule

// ### verif/gsir_bus_model.sv
// Far side of the bank: bus engine levels and one-cycle event pulses.
// Assumes the bench calls the tasks from its main sequence, one at a time.
`timescale 1ns/1ps

module gsir_bus_model
(
	input  wire logic             pclk,
	output gsir_pkg::gsir_lines_t lines,
	output logic [7:0]            dio,
	output gsir_pkg::gsir_proto_t proto,
	output gsir_pkg::gsir_mode_t  mode,
	output gsir_pkg::gsir_evt_t   evt
);
	initial
	begin
		lines = '0;
		dio = 8'h00;
		proto = '0;
		mode = '0;
		evt = '0;
	end

	task automatic set_levels(input logic [7:0] l, input logic [7:0] d,
		input logic [7:0] p, input logic [3:0] m);
		@(posedge pclk);
		lines <= l;
		dio <= d;
		proto <= p;
		mode <= m;
	endtask

	// The engine reports each event for exactly one cycle
	task automatic pulse(input logic [10:0] e);
		@(posedge pclk);
		evt <= e;
		@(posedge pclk);
		evt <= '0;
	endtask
endmodule

// ### verif/gsir_status_interrupt_regs_tb_top.sv
// Self-checking bench for the status/interrupt bank over APB.
// Assumes gsir_regs.svh is on the include path.
`timescale 1ns/1ps
`include "gsir_regs.svh"

module gsir_status_interrupt_regs_tb_top;
	logic                    pclk;
	logic                    presetn;
	gsir_pkg::gsir_apb_req_t apb_req;
	logic [31:0]             prdata;
	logic                    pready;
	logic                    pslverr;
	gsir_pkg::gsir_lines_t   lines;
	logic [7:0]              dio;
	gsir_pkg::gsir_proto_t   proto;
	gsir_pkg::gsir_mode_t    mode;
	gsir_pkg::gsir_evt_t     evt;
	logic                    irq;
	logic [1:0]              dma_enable;
	logic                    data_lines_read;
	logic [31:0]             s_rd;
	logic                    s_err;
	logic                    s_dlr;
	int                      errors;
	int                      n_checks;
	int                      cycles = 0;
	logic [7:0]              lo_bit [7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h04, 8'h02, 8'h01};

	gsir_top uut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .lines(lines), .dio(dio), .proto(proto),
		.mode(mode), .evt(evt), .irq(irq), .dma_enable(dma_enable),
		.data_lines_read(data_lines_read));

	gsir_bus_model bm (.pclk(pclk), .lines(lines), .dio(dio), .proto(proto), .mode(mode),
		.evt(evt));

	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// Answer taken at the completing edge, before any release lands
	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		if (apb_req.psel && apb_req.penable && pready)
		begin
			s_rd <= prdata;
			s_err <= pslverr;
			s_dlr <= data_lines_read;
		end
	end

	task automatic test_done();
		if (errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	always @(posedge pclk)
	begin
		if (cycles == 20000)
		begin
			errors++;
			test_done();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Waits for pready with no limit of its own; the bench timeout ends a hang
	task automatic apb(input logic wr, input logic [6:0] a, input logic [7:0] wd);
		@(posedge pclk);
		apb_req <= '{1'b1, 1'b0, wr, a, {24'h000000, wd}};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		apb_req <= '0;
		@(negedge pclk);
	endtask

	task automatic wr(input logic [4:0] i, input logic [7:0] d);
		apb(1'b1, {i, 2'b00}, d);
		chk("write_error", 32'h0, {31'h0, s_err});
	endtask

	task automatic rdchk(input logic [4:0] i, input logic [7:0] e, input string nm);
		apb(1'b0, {i, 2'b00}, 8'h00);
		chk(nm, {24'h00_0000, e}, s_rd);
		chk("read_error", 32'h0, {31'h0, s_err});
	endtask

	task automatic wait_irq(input logic e);
		int n;
		n = 0;
		while (irq !== e && n < 4)
		begin
			@(posedge pclk);
			n++;
		end
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask

	initial
	begin
		presetn = 1'b0;
		apb_req = '0;
		errors = 0;
		n_checks = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		wr(`GSIR_IDX_HIGH, 8'h3F);
		wr(`GSIR_IDX_LOW, 8'hFF);
		wr(`GSIR_IDX_ENABLE, 8'h83);
		chk("dma_enable", 32'h3, {30'h0, dma_enable});
		bm.pulse(11'h400);
		wait_irq(1'b1);
		rdchk(`GSIR_IDX_ENABLE, 8'hC3, "enable_view");
		wr(`GSIR_IDX_HIGH, 8'h1F);
		wait_irq(1'b0);
		wr(`GSIR_IDX_HIGH, 8'h3F);
		wait_irq(1'b1);
		// Don't-care bits set, enables cleared
		wr(`GSIR_IDX_ENABLE, 8'h7C);
		wait_irq(1'b0);
		chk("dma_enable", 32'h0, {30'h0, dma_enable});
		rdchk(`GSIR_IDX_HIGH, 8'hA0, "cause_high");
		bm.set_levels(8'h00, 8'h00, 8'h00, 4'h1);
		for (int k = 0; k < 10; k++)
		begin
			bm.pulse(11'h400 >> k);
			if (k < 3)
				rdchk(`GSIR_IDX_HIGH, 8'h80 | (8'h20 >> k), "cause_high");
			else
			begin
				rdchk(`GSIR_IDX_HIGH, 8'h40, "summary_low");
				rdchk(`GSIR_IDX_LOW, lo_bit[k - 3], "cause_low");
			end
			rdchk((k < 3) ? `GSIR_IDX_HIGH : `GSIR_IDX_LOW, 8'h00, "cleared");
		end
		// Qualifiers off: neither cause may appear
		bm.set_levels(8'h80, 8'h00, 8'h00, 4'h0);
		bm.pulse(11'h110);
		rdchk(`GSIR_IDX_HIGH, 8'h00, "end_under_atn");
		rdchk(`GSIR_IDX_LOW, 8'h00, "secaddr_basic");
		bm.set_levels(8'h00, 8'h00, 8'h80, 4'h8);
		rdchk(`GSIR_IDX_HIGH, 8'h86, "remote_serial_poll_active");
		bm.set_levels(8'h00, 8'h00, 8'h84, 4'h8);
		rdchk(`GSIR_IDX_HIGH, 8'h81, "addr_change");
		bm.set_levels(8'h00, 8'h00, 8'h84, 4'h4);
		rdchk(`GSIR_IDX_HIGH, 8'h40, "summary_low");
		rdchk(`GSIR_IDX_LOW, 8'h08, "dcas");
		bm.set_levels(8'hFF, 8'h5A, 8'hA5, 4'h0);
		rdchk(`GSIR_IDX_PROTO, 8'hA5, "proto");
		rdchk(`GSIR_IDX_LINES, 8'hCB, "lines_masked");
		chk("dlr_idle", 32'h0, {31'h0, s_dlr});
		rdchk(`GSIR_IDX_DATA, 8'h5A, "dio");
		chk("dlr_pulse", 32'h1, {31'h0, s_dlr});
		bm.set_levels(8'hFF, 8'h3C, 8'hA7, 4'h2);
		rdchk(`GSIR_IDX_LINES, 8'hFF, "lines_full");
		bm.pulse(11'h001);
		bm.set_levels(8'hFF, 8'hC3, 8'hA7, 4'h2);
		rdchk(`GSIR_IDX_SECCMD, 8'h3C, "seccmd");
		// Read-only, unmapped and unaligned places are refused
		apb(1'b1, 7'h54, 8'hFF);
		chk("ro_write_err", 32'h1, {31'h0, s_err});
		apb(1'b0, 7'h00, 8'h00);
		chk("unmapped_err", 32'h1, {31'h0, s_err});
		apb(1'b0, 7'h45, 8'h00);
		chk("unaligned_err", 32'h1, {31'h0, s_err});
		// Mid-run reset with levels high: no false edges after release
		wr(`GSIR_IDX_ENABLE, 8'h81);
		bm.pulse(11'h400);
		wait_irq(1'b1);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("reset_irq", 32'h0, {31'h0, irq});
		chk("reset_dma", 32'h0, {30'h0, dma_enable});
		presetn <= 1'b1;
		rdchk(`GSIR_IDX_HIGH, 8'h00, "reset_cause");
		rdchk(`GSIR_IDX_ENABLE, 8'h00, "reset_enable");
		rdchk(`GSIR_IDX_PROTO, 8'hA7, "proto");
		test_done();
	end
endmodule
